/* File: pkg/timer_consts.vh */
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH
`define REG_ENABLE      8'h00
`define REG_CTRL        8'h04
`define REG_RELOAD      8'h08
`define REG_COUNT       8'h0C
`define REG_THR_HIGH    8'h10
`define REG_THR_LOW     8'h14
`define REG_CASCADE     8'h18
`define REG_IRQ_STATUS  8'h1C
`define REG_IRQ_MASK    8'h20
`define REG_PIN_EDGE    8'h24
`define CTRL_SEL_LSB    0
`define CTRL_SEL_MSB    1
`define CTRL_IRQ_EN     2
`define SEL_PULSE       2'h0
`define SEL_ACTIVE      2'h1
`define SEL_PWM_EDGE    2'h2
`define SEL_PWM_CENTER  2'h3
`define CAS_SRC_LSB     0
`define CAS_SRC_MSB     4
`define CAS_MODE_LSB    8
`define CAS_MODE_MSB    10
`define CAS_OFF         3'h0
`define CAS_START       3'h1
`define CAS_STOP        3'h2
`define CAS_LEVEL_HIGH  3'h3
`define CAS_LEVEL_LOW   3'h4
`define EDGE_RISE       2'h0
`define EDGE_FALL       2'h1
`define EDGE_BOTH       2'h2
`define IRQ_ZERO        0
`define IRQ_TRIG        1
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

/* File: logic/pin_event.v */
`include "timer_consts.vh"
module pin_event
(
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       pin,
    input  wire [1:0] edge_sel,
    output wire       level,
    output reg        evt
);
    reg [2:0] sync_q;
    reg       level_q;
    wire      agree;
    wire      rise;
    wire      fall;

    assign agree = (sync_q[1] == sync_q[2]);
    assign rise  = agree && sync_q[2] && !level_q;
    assign fall  = agree && !sync_q[2] && level_q;
    assign level = level_q;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync_q  <= 3'h0;
            level_q <= 1'b0;
            evt     <= 1'b0;
        end
        else
        begin
            sync_q <= {sync_q[1:0], pin};
            if (agree)
            begin
                level_q <= sync_q[2];
            end
            case (edge_sel) // RL10
                `EDGE_RISE: evt <= rise;
                `EDGE_FALL: evt <= fall;
                default:    evt <= rise | fall;
            endcase
        end
    end
endmodule

/* File: logic/cascaded_down_timer_pwm.v */
// Function
// RL1: In center PWM mode the output is high while the count is below the high threshold and above the low threshold.
// RL2: On reaching zero the count reloads from the reload register and keeps counting.
// RL3: Both thresholds are software registers, so both output edges can be placed anywhere in the period.
// RL4: With selector zero the output gives a one-cycle pulse each time the count reaches zero.
// RL5: With the interrupt enable set, the zero event raises an interrupt.
// RL6: A selectable pin trigger source can start counting.
// RL7: A trigger event either starts or stops counting, as configured.
// RL8: Level gating counts only while the selected pin is high, or only while it is low.
// RL9: Any pin event can be chosen as the trigger input.
// RL10: Each pin event fires on rising, falling or both edges; only pins 0 to 15 are settable, pins 16 to 31 stay on rising.
// RL11: A debug halt does not affect the channel.
// RL12: The channel keeps running in processor wait, and its interrupt can wake the processor.
// RL13: The channel is one of many identical independent instances, each a periodic interrupt source.
// RL14: The count is a 32-bit down counter, decremented per enabled cycle and writable by software.
`include "timer_consts.vh"
module cascaded_down_timer_pwm // RL13
#(
    parameter NUM_PINS = 32
)
(
    input  wire                aclk,
    input  wire                aresetn,
    input  wire [7:0]          s_axi_awaddr,
    input  wire                s_axi_awvalid,
    output wire                s_axi_awready,
    input  wire [31:0]         s_axi_wdata,
    input  wire [3:0]          s_axi_wstrb,
    input  wire                s_axi_wvalid,
    output wire                s_axi_wready,
    output reg  [1:0]          s_axi_bresp,
    output reg                 s_axi_bvalid,
    input  wire                s_axi_bready,
    input  wire [7:0]          s_axi_araddr,
    input  wire                s_axi_arvalid,
    output wire                s_axi_arready,
    output reg  [31:0]         s_axi_rdata,
    output reg  [1:0]          s_axi_rresp,
    output reg                 s_axi_rvalid,
    input  wire                s_axi_rready,
    input  wire [NUM_PINS-1:0] port_pins,
    input  wire                cpu_halted,
    input  wire                cpu_waiting,
    output reg                 status_out,
    output wire                irq,
    output wire                wake_req
);
    reg  [31:0]         enable_q;
    reg  [31:0]         ctrl_q;
    reg  [31:0]         reload_q;
    reg  [31:0]         count_q;
    reg  [31:0]         thr_high_q;
    reg  [31:0]         thr_low_q;
    reg  [31:0]         cascade_q;
    reg  [1:0]          irq_status_q;
    reg  [1:0]          irq_mask_q;
    reg  [2*NUM_PINS-1:0] pin_edge_q;
    reg  [7:0]          awaddr_q;
    reg                 aw_held_q;
    reg  [31:0]         wdata_q;
    reg  [3:0]          wstrb_q;
    reg                 w_held_q;
    reg                 run_q;
    reg  [31:0]         rd_d;
    reg                 rd_ok;
    reg                 wr_ok;
    reg  [31:0]         wmask;
    wire [NUM_PINS-1:0] pin_lvl;
    wire [NUM_PINS-1:0] pin_evt;
    wire [4:0]          cas_src;
    wire [2:0]          cas_mode;
    wire                trig_evt;
    wire                trig_lvl;
    wire                count_ok;
    wire                at_zero;
    wire                do_write;
    wire [1:0]          status_sel;
    wire                zero_evt;
    integer             i;

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g = g + 1)
        begin : pins
            pin_event u_evt
            (
                .aclk     (aclk),
                .aresetn  (aresetn),
                .pin      (port_pins[g]),
                .edge_sel (pin_edge_q[2*g+1:2*g]), // RL10
                .level    (pin_lvl[g]),
                .evt      (pin_evt[g])
            );
        end
    endgenerate

    assign cas_src    = cascade_q[`CAS_SRC_MSB:`CAS_SRC_LSB];
    assign cas_mode   = cascade_q[`CAS_MODE_MSB:`CAS_MODE_LSB];
    assign trig_evt   = pin_evt[cas_src]; // RL9
    assign trig_lvl   = pin_lvl[cas_src];
    assign status_sel = ctrl_q[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
    assign count_ok   = enable_q[0] && run_q &&
                        !((cas_mode == `CAS_LEVEL_HIGH) && !trig_lvl) &&
                        !((cas_mode == `CAS_LEVEL_LOW) && trig_lvl); // RL8
    assign at_zero    = (count_q == 32'h0);
    assign zero_evt   = count_ok && at_zero;
    assign do_write   = aw_held_q && w_held_q && !s_axi_bvalid;
    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready  = !w_held_q;
    assign s_axi_arready = !s_axi_rvalid;
    assign irq        = |(irq_status_q & irq_mask_q);
    assign wake_req   = irq; // RL12

    always @*
    begin
        wmask = 32'h0;
        for (i = 0; i < 4; i = i + 1)
        begin
            wmask[8*i +: 8] = {8{wstrb_q[i]}};
        end
        wr_ok = 1'b1;
        case (awaddr_q)
            `REG_ENABLE, `REG_CTRL, `REG_RELOAD, `REG_COUNT, `REG_THR_HIGH,
            `REG_THR_LOW, `REG_CASCADE, `REG_IRQ_STATUS, `REG_IRQ_MASK,
            `REG_PIN_EDGE: wr_ok = 1'b1;
            default:       wr_ok = 1'b0;
        endcase
        rd_ok = 1'b1;
        rd_d  = 32'h0;
        case (s_axi_araddr)
            `REG_ENABLE:     rd_d = {31'h0, enable_q[0]};
            `REG_CTRL:       rd_d = {29'h0, ctrl_q[2:0]};
            `REG_RELOAD:     rd_d = reload_q;
            `REG_COUNT:      rd_d = count_q;
            `REG_THR_HIGH:   rd_d = thr_high_q;
            `REG_THR_LOW:    rd_d = thr_low_q;
            `REG_CASCADE:    rd_d = {21'h0, cascade_q[10:8], 3'h0, cascade_q[4:0]};
            `REG_IRQ_STATUS: rd_d = {30'h0, irq_status_q};
            `REG_IRQ_MASK:   rd_d = {30'h0, irq_mask_q};
            `REG_PIN_EDGE:   rd_d = pin_edge_q[31:0];
            default:         rd_ok = 1'b0;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            awaddr_q     <= 8'h0;
            wdata_q      <= 32'h0;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `RESP_OKAY;
            s_axi_rdata  <= 32'h0;
        end
        else
        begin
            if (s_axi_awvalid && !aw_held_q)
            begin
                aw_held_q <= 1'b1;
                awaddr_q  <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && !w_held_q)
            begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
            end
            if (s_axi_arvalid && !s_axi_rvalid)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_ok ? rd_d : 32'h0;
                s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Register writes; the counter and its run state share this process.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable_q     <= 32'h0;
            ctrl_q       <= 32'h0;
            reload_q     <= 32'h0;
            count_q      <= 32'h0;
            thr_high_q   <= 32'h0;
            thr_low_q    <= 32'h0;
            cascade_q    <= 32'h0;
            irq_status_q <= 2'h0;
            irq_mask_q   <= 2'h0;
            pin_edge_q   <= {(2*NUM_PINS){1'b0}};
            run_q        <= 1'b1;
            status_out   <= 1'b0;
        end
        else
        begin
            // Trigger handling: start mode waits for an event, stop mode halts on one.
            if (cas_mode == `CAS_START)
            begin
                if (trig_evt)
                begin
                    run_q <= 1'b1; // RL6 RL7
                end
            end
            else if (cas_mode == `CAS_STOP)
            begin
                if (trig_evt)
                begin
                    run_q <= 1'b0; // RL7
                end
            end
            else
            begin
                run_q <= 1'b1;
            end
            // Counting ignores cpu_halted and cpu_waiting entirely.
            if (count_ok) // RL11
            begin
                if (at_zero)
                begin
                    count_q <= reload_q; // RL2
                end
                else
                begin
                    count_q <= count_q - 32'h1; // RL14
                end
            end
            // Set beats clear on the sticky status bits.
            irq_status_q <= (irq_status_q &
                             ~((do_write && awaddr_q == `REG_IRQ_STATUS) ? wdata_q[1:0] : 2'h0))
                            | {count_ok && trig_evt, zero_evt && ctrl_q[`CTRL_IRQ_EN]}; // RL5
            case (status_sel)
                `SEL_PULSE:      status_out <= zero_evt; // RL4
                `SEL_ACTIVE:     status_out <= count_ok;
                `SEL_PWM_EDGE:   status_out <= (count_q < thr_high_q);
                `SEL_PWM_CENTER: status_out <= (count_q < thr_high_q) && (count_q > thr_low_q); // RL1
                default:         status_out <= 1'b0;
            endcase
            if (do_write)
            begin
                case (awaddr_q)
                    `REG_ENABLE:   enable_q   <= (enable_q & ~wmask) | (wdata_q & wmask & 32'h1);
                    `REG_CTRL:     ctrl_q     <= (ctrl_q & ~wmask) | (wdata_q & wmask & 32'h7);
                    `REG_RELOAD:   reload_q   <= (reload_q & ~wmask) | (wdata_q & wmask);
                    `REG_COUNT:    count_q    <= (count_q & ~wmask) | (wdata_q & wmask); // RL14
                    `REG_THR_HIGH: thr_high_q <= (thr_high_q & ~wmask) | (wdata_q & wmask); // RL3
                    `REG_THR_LOW:  thr_low_q  <= (thr_low_q & ~wmask) | (wdata_q & wmask); // RL3
                    `REG_CASCADE:
                    begin
                        cascade_q <= (cascade_q & ~wmask) | (wdata_q & wmask & 32'h071F);
                        run_q     <= (wdata_q[`CAS_MODE_MSB:`CAS_MODE_LSB] != `CAS_START);
                    end
                    `REG_IRQ_MASK: irq_mask_q <= wdata_q[1:0];
                    `REG_PIN_EDGE: pin_edge_q[31:0] <= (pin_edge_q[31:0] & ~wmask) | (wdata_q & wmask);
                    default:       enable_q <= enable_q;
                endcase
            end
        end
    end
endmodule

/* File: dv/timer_chk.sv */
`include "timer_consts.vh"
module timer_chk (
    input logic        aclk,
    input logic        aresetn,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [7:0]  s_axi_araddr,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic        irq,
    input logic        wake_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wake_follow_a: assert property (wake_req == irq)
        else $error("wake request differs from irq");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    read_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h24
        |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule

bind cascaded_down_timer_pwm timer_chk i_timer_chk (.*);

/* File: dv/pin_stim.sv */
module pin_stim (
    input  logic        aclk,
    output logic [31:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] div = 3'h0;
    initial
        pins = 32'h0;
    // An unselected pin toggles every eight cycles so a wrong pin select shows up.
    always @(posedge aclk)
    begin
        div <= div + 3'h1;
        if (div == 3'h7)
            pins[0] <= ~pins[0];
    end
    task automatic put(input int idx, input logic v);
        pins[idx] <= v;
    endtask
endmodule

/* File: dv/tb_cascaded_down_timer_pwm.sv */
`include "timer_consts.vh"
module tb_cascaded_down_timer_pwm;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        cpu_halted = 1'b0;
    logic        cpu_waiting = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
    logic [31:0] s_axi_rdata, port_pins, rv;
    logic        status_out, irq, wake_req;
    int          mismatches = 0;
    int          compares = 0;
    always #12.5 aclk = ~aclk;
    cascaded_down_timer_pwm i_cascaded_down_timer_pwm (.*);
    pin_stim i_pin_stim (.aclk(aclk), .pins(port_pins));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
                break;
            s_axi_bready <= s_axi_bvalid;
        end
        s_axi_bready <= 1'b0;
        br = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
                break;
            s_axi_rready <= s_axi_rvalid;
        end
        s_axi_rready <= 1'b0;
        rv = s_axi_rdata;
        rr = s_axi_rresp;
    endtask
    task automatic run_chk(input logic exp);
        logic [31:0] a;
        cyc(8);
        rd(`REG_COUNT);
        a = rv;
        cyc(3);
        rd(`REG_COUNT);
        chk({31'h0, a !== rv}, {31'h0, exp});
        chk({31'h0, status_out}, {31'h0, exp});
    endtask
    task automatic t_reset;
        rd(`REG_CTRL);
        chk(rv, 32'h0);
        rd(8'h40);
        chk({30'h0, rr}, {30'h0, `RESP_SLVERR});
        wr(8'h40, 32'h0);
        chk({30'h0, br}, {30'h0, `RESP_SLVERR});
        wr(`REG_COUNT, 32'h12345678);
        chk({30'h0, br}, {30'h0, `RESP_OKAY});
        rd(`REG_COUNT);
        chk(rv, 32'h12345678);
    endtask
    task automatic t_pulse;
        int n;
        wr(`REG_RELOAD, 32'h9);
        wr(`REG_COUNT, 32'h9);
        wr(`REG_CTRL, 32'h4);
        wr(`REG_IRQ_MASK, 32'h1);
        wr(`REG_ENABLE, 32'h1);
        while (status_out !== 1'b1)
            @(posedge aclk);
        @(posedge aclk);
        chk({31'h0, status_out}, 32'h0);
        n = 1;
        while (status_out !== 1'b1)
        begin
            @(posedge aclk);
            n++;
        end
        chk(n, 32'hA);
        chk({31'h0, irq}, 32'h1);
        wr(`REG_IRQ_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(`REG_ENABLE, 32'h0);
        wr(`REG_IRQ_STATUS, 32'h1);
        wr(`REG_IRQ_MASK, 32'h1);
        rd(`REG_IRQ_STATUS);
        chk({rv[31:2], rv[0], irq}, 32'h0);
    endtask
    task automatic t_pwm;
        int n;
        wr(`REG_RELOAD, 32'h13);
        wr(`REG_COUNT, 32'h13);
        wr(`REG_CTRL, {30'h0, `SEL_PWM_CENTER});
        wr(`REG_ENABLE, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            if (i == 2)
                wr(`REG_CTRL, {30'h0, `SEL_PWM_EDGE});
            wr(`REG_THR_HIGH, i ? 32'h0B : 32'h0F);
            wr(`REG_THR_LOW, i ? 32'h08 : 32'h05);
            cyc(3);
            n = 0;
            repeat (40)
            begin
                @(posedge aclk);
                if (status_out === 1'b1)
                    n++;
            end
            chk(n, (i == 0) ? 32'h12 : ((i == 1) ? 32'h4 : 32'h16));
        end
        wr(`REG_ENABLE, 32'h0);
    endtask
    task automatic t_cascade;
        wr(`REG_RELOAD, 32'h3E8);
        wr(`REG_CTRL, {30'h0, `SEL_ACTIVE});
        wr(`REG_PIN_EDGE, {24'h0, `EDGE_FALL, 6'h0});
        wr(`REG_CASCADE, {21'h0, `CAS_START, 8'h03});
        wr(`REG_ENABLE, 32'h1);
        run_chk(1'b0);
        i_pin_stim.put(3, 1'b1);
        run_chk(1'b0);
        i_pin_stim.put(3, 1'b0);
        run_chk(1'b1);
        cpu_halted <= 1'b1;
        cpu_waiting <= 1'b1;
        wr(`REG_PIN_EDGE, {24'h0, `EDGE_BOTH, 6'h0});
        wr(`REG_CASCADE, {21'h0, `CAS_STOP, 8'h03});
        run_chk(1'b1);
        wr(`REG_IRQ_STATUS, 32'h2);
        i_pin_stim.put(3, 1'b1);
        run_chk(1'b0);
        rd(`REG_IRQ_STATUS);
        chk({31'h0, rv[1]}, 32'h1);
        wr(`REG_PIN_EDGE, 32'h0);
        wr(`REG_CASCADE, {21'h0, `CAS_START, 8'h03});
        i_pin_stim.put(3, 1'b0);
        run_chk(1'b0);
        i_pin_stim.put(3, 1'b1);
        run_chk(1'b1);
    endtask
    task automatic t_gate;
        wr(`REG_CASCADE, {21'h0, `CAS_LEVEL_HIGH, 8'h03});
        run_chk(1'b1);
        i_pin_stim.put(3, 1'b0);
        run_chk(1'b0);
        wr(`REG_CASCADE, {21'h0, `CAS_LEVEL_LOW, 8'h03});
        run_chk(1'b1);
    endtask
    task automatic give_verdict;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        cyc(6);
        aresetn <= 1'b1;
        cyc(1);
        t_reset;
        t_pulse;
        t_pwm;
        t_cascade;
        t_gate;
        give_verdict;
    end
    initial
    begin
        cyc(20000);
        mismatches++;
        give_verdict;
    end
endmodule
